// ### logic/hps_supervisor.sv
// Module: host power supervisor top with Wishbone command registers
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
module hps_supervisor
	import hps_pkg::*;
#(
	parameter int unsigned NFAN = 4,
	parameter int unsigned CYC_STEP = CYC_PWM_STEP,
	parameter int unsigned CYC_TK = CYC_TICK
)(
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic hostAlive,
	input wire logic keyConfirm,
	input wire logic keyCancel,
	input wire logic [NFAN-1:0] tachIn,
	input wire logic [NFAN-1:0] failSafeMask,
	output logic [NFAN-1:0] fanPwm,
	output logic [NFAN-1:0] tachValid,
	output logic hostResetOut,
	output logic hostResetOe,
	output logic hostPowerOut,
	output logic hostPowerOe,
	output logic displayBlank,
	output logic selfRestart,
	output logic [1:0] msgSel
);
	localparam int unsigned PW = $clog2(CYC_STEP + 1);
	localparam int unsigned TW = $clog2(CYC_TK + 1);
	localparam logic [PW-1:0] STEP_LAST = PW'(CYC_STEP - 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(CYC_TK - 1);
	localparam logic [6:0] PH_LAST = 7'(PWM_STEPS - 1);
	localparam logic [7:0] TK_SEC = 8'(TICKS_SEC);
	localparam logic [7:0] TK_LONG = 8'(HOLD_LONG_SEC * TICKS_SEC);
	localparam logic [7:0] TK_SHORT = 8'(HOLD_SHORT_TICKS);
	localparam logic [7:0] TK_EXTRA = 8'(EXTRA_SEC * TICKS_SEC);
	localparam logic [7:0] TK_RST = 8'(RESET_PULSE_SEC * TICKS_SEC);

	// ------------------------------------------------------------
	// Software-visible state
	// ------------------------------------------------------------
	logic [31:0] cmd_q, arg0_q, arg1_q;
	logic [7:0] reply_q;
	logic [31:0] data0_q;
	logic [7:0] data1_q;
	logic [7:0] enable_q;
	logic [7:0] pulseLen_q;
	logic [7:0] blankDly_q [NFAN];
	logic [8*NFAN-1:0] fanPower_q;
	logic [7:0] wdTimeout_q;
	logic [7:0] wdSec_q;
	logic [7:0] wdTick_q;
	logic ack_q;
	logic [31:0] rdata_q;

	// ------------------------------------------------------------
	// Time base: PWM step strobe and 1/32 s tick
	// ------------------------------------------------------------
	logic [PW-1:0] stepCnt_q;
	logic [6:0] phase_q;
	logic [TW-1:0] tickCnt_q;
	logic stepTick, tick;
	assign stepTick = (stepCnt_q == STEP_LAST);
	assign tick = (tickCnt_q == TICK_LAST);

	// 100 steps per PWM period give the ~18 Hz rate
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			stepCnt_q <= '0;
			phase_q <= 7'h00;
		end else if (ce) begin
			stepCnt_q <= stepTick ? '0 : stepCnt_q + PW'(1);
			if (stepTick) begin
				phase_q <= (phase_q == PH_LAST) ? 7'h00 : phase_q + 7'h01;
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			tickCnt_q <= '0;
		end else if (ce) begin
			tickCnt_q <= tick ? '0 : tickCnt_q + TW'(1);
		end
	end

	// ------------------------------------------------------------
	// Fan channels
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NFAN; gi++) begin : g_fan
			hps_fan_if fi ();
			assign fi.phase = phase_q;
			assign fi.stepTick = stepTick;
			assign fi.power = fanPower_q[8*gi +: 8];
			assign fi.delay = blankDly_q[gi];
			assign fanPwm[gi] = fi.pwmOn;
			assign tachValid[gi] = fi.tachOk & tachIn[gi];
			hps_fan_chan u_chan (
				.mclk(mclk),
				.reset(reset),
				.ce(ce),
				.f(fi.fan)
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Wishbone decode
	// ------------------------------------------------------------
	wire busReq = wb_cyc_i && wb_stb_i && !ack_q;
	wire busWr = busReq && wb_we_i;
	wire wrCmd = busWr && (wb_adr_i == A_CMD) && wb_sel_i[0];
	wire wrArg0 = busWr && (wb_adr_i == A_ARG0);
	wire wrArg1 = busWr && (wb_adr_i == A_ARG1);
	wire wrFan = busWr && (wb_adr_i == A_FANPWR);

	// Sequencer state declared here, read by the command path
	hps_state_t state_q, state_d;
	logic lockout;
	assign lockout = (state_q == HPS_LOCK);
	wire exec = wrCmd && !lockout;

	// Byte-lane merge for argument and fan power registers
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ack_q <= 1'b0;
		end else if (ce) begin
			ack_q <= busReq;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	// ------------------------------------------------------------
	// Read mux; unmapped addresses read zero
	// ------------------------------------------------------------
	logic [31:0] rmux;
	always_comb begin
		case (wb_adr_i)
			A_CMD: rmux = cmd_q;
			A_ARG0: rmux = arg0_q;
			A_ARG1: rmux = arg1_q;
			A_REPLY: rmux = {24'h000000, reply_q};
			A_DATA0: rmux = data0_q;
			A_DATA1: rmux = {24'h000000, data1_q};
			A_STATUS: rmux = {8'h00, wdTimeout_q, enable_q,
				2'b00, lockout, hostAlive, 4'h0};
			A_FANPWR: rmux = fanPower_q[31:0];
			default: rmux = 32'h00000000;
		endcase
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rdata_q <= 32'h00000000;
		end else if (ce && busReq) begin
			rdata_q <= rmux;
		end
	end

	// ------------------------------------------------------------
	// Command registers and request execution
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cmd_q <= 32'h00000000;
			arg0_q <= 32'h00000000;
			arg1_q <= 32'h00000000;
			fanPower_q <= '0;
		end else if (ce) begin
			if (wrCmd) cmd_q <= merge(cmd_q, wb_dat_i, wb_sel_i);
			if (wrArg0) arg0_q <= merge(arg0_q, wb_dat_i, wb_sel_i);
			if (wrArg1) arg1_q <= merge(arg1_q, wb_dat_i, wb_sel_i);
			if (wrFan) fanPower_q <= merge(fanPower_q, wb_dat_i, wb_sel_i);
		end
	end

	// Type is taken from the written command word itself
	wire [7:0] newType = wb_dat_i[7:0];
	wire [2:0] newLen = wb_dat_i[CMD_LEN_LO +: 3];
	wire doBlank = exec && (newType == T_BLANK);
	wire doQuery = exec && (newType == T_QUERY);
	wire doEnable = exec && (newType == T_ENABLE);
	wire doWdog = exec && (newType == T_WDOG);
	wire known = doBlank || doQuery || doEnable || doWdog;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			reply_q <= 8'h00;
			data0_q <= 32'h00000000;
			data1_q <= 8'h00;
			enable_q <= 8'h00;
			pulseLen_q <= DEF_PULSE_TICKS;
			for (int i = 0; i < NFAN; i++) begin
				blankDly_q[i] <= DEF_BLANK;
			end
		end else if (ce) begin
			if (known) reply_q <= newType | T_REPLY_BIT;
			if (doBlank) begin
				for (int i = 0; i < NFAN; i++) begin
					blankDly_q[i] <= arg0_q[8*i +: 8];
				end
			end
			if (doQuery) begin
				data0_q <= fanPower_q[31:0];
				data1_q <= 8'(failSafeMask);
			end
			if (doEnable) begin
				enable_q <= arg0_q[7:0];
				pulseLen_q <= (newLen >= 3'd2) ? arg0_q[15:8]
					: DEF_PULSE_TICKS;
			end
		end
	end

	// ------------------------------------------------------------
	// Watchdog: seconds down-counter
	// ------------------------------------------------------------
	logic wdFire;
	assign wdFire = (wdTimeout_q != 8'h00) && (wdSec_q == 8'h00);
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wdTimeout_q <= 8'h00;
			wdSec_q <= 8'h00;
			wdTick_q <= 8'h00;
		end else if (ce) begin
			if (doWdog) begin
				wdTimeout_q <= arg0_q[7:0];
				wdSec_q <= arg0_q[7:0];
				wdTick_q <= 8'h00;
			end else if (wdFire) begin
				wdTimeout_q <= 8'h00;
			end else if (wdTimeout_q != 8'h00 && tick) begin
				if (wdTick_q == TK_SEC - 8'h01) begin
					wdTick_q <= 8'h00;
					wdSec_q <= wdSec_q - 8'h01;
				end else begin
					wdTick_q <= wdTick_q + 8'h01;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Keypad sequencer
	// ------------------------------------------------------------
	logic [7:0] tk_q, tk_d;
	logic [1:0] act_q, act_d; // 1 reset, 2 power-on, 3 power-off
	logic wdPend_q;
	always_comb begin
		state_d = state_q;
		tk_d = tk_q;
		act_d = act_q;
		case (state_q)
			HPS_IDLE: begin
				tk_d = 8'h00;
				if (wdPend_q) begin
					act_d = 2'd0;
					tk_d = TK_RST;
					state_d = HPS_PULSE;
				end else if (keyConfirm && hostAlive && enable_q[B_KRST]) begin
					act_d = 2'd1;
					state_d = HPS_HOLD;
				end else if (keyConfirm && !hostAlive && enable_q[B_KON]) begin
					act_d = 2'd2;
					state_d = HPS_HOLD;
				end else if (keyCancel && hostAlive && enable_q[B_KOFF]) begin
					act_d = 2'd3;
					state_d = HPS_HOLD;
				end
			end
			HPS_HOLD: begin
				if ((act_q == 2'd3) ? !keyCancel : !keyConfirm) begin
					state_d = HPS_IDLE;
				end else if (tick) begin
					tk_d = tk_q + 8'h01;
					if (tk_q + 8'h01 == ((act_q == 2'd2) ? TK_SHORT : TK_LONG)) begin
						tk_d = (act_q == 2'd1) ? TK_RST : pulseLen_q;
						state_d = HPS_PULSE;
					end
				end
			end
			HPS_PULSE: begin
				if (tick) tk_d = tk_q - 8'h01;
				if (tick && tk_q <= 8'h01) begin
					if (act_q == 2'd3 && keyCancel) begin
						tk_d = TK_EXTRA;
						state_d = HPS_EXTRA;
					end else if (act_q == 2'd0 || act_q == 2'd3) begin
						state_d = HPS_WAITREL;
					end else begin
						state_d = HPS_LOCK;
					end
				end
			end
			HPS_EXTRA: begin
				if (tick) tk_d = tk_q - 8'h01;
				if (!keyCancel || (tick && tk_q <= 8'h01)) begin
					state_d = HPS_WAITREL;
				end
			end
			HPS_LOCK: state_d = HPS_LOCK; // held until selfRestart resets
			HPS_WAITREL: begin
				if (!keyConfirm && !keyCancel) state_d = HPS_IDLE;
			end
			default: state_d = HPS_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_q <= HPS_IDLE;
			tk_q <= 8'h00;
			act_q <= 2'd0;
			wdPend_q <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			tk_q <= tk_d;
			act_q <= act_d;
			// Expiry latched so a busy sequencer cannot lose it
			if (wdFire) wdPend_q <= 1'b1;
			else if (state_q == HPS_IDLE) wdPend_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Control pins and display
	// ------------------------------------------------------------
	wire driving = (state_q == HPS_PULSE) || (state_q == HPS_EXTRA);
	wire resetAct = enable_q[B_RSTINV];
	wire powerAct = enable_q[B_PWRINV];
	logic hostAlive_q;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			hostResetOe <= 1'b0;
			hostPowerOe <= 1'b0;
			hostResetOut <= 1'b0;
			hostPowerOut <= 1'b0;
			hostAlive_q <= 1'b0;
			selfRestart <= 1'b0;
		end else if (ce) begin
			hostResetOe <= driving && (act_q <= 2'd1);
			hostPowerOe <= driving && (act_q >= 2'd2);
			hostResetOut <= resetAct;
			hostPowerOut <= powerAct;
			hostAlive_q <= hostAlive;
			// Sticky until reset, so a slow feedback path cannot miss it
			selfRestart <= selfRestart || lockout
				|| (enable_q[B_BLANK] && hostAlive
				&& !hostAlive_q);
		end
	end
	assign displayBlank = enable_q[B_BLANK] && !hostAlive;
	assign msgSel = driving ? ((act_q <= 2'd1) ? 2'd1
		: (act_q == 2'd2) ? 2'd2 : 2'd3) : 2'd0;
endmodule

// ### logic/hps_pkg.sv
// Package: constants, command codes and timing for the host power supervisor
package hps_pkg;
	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 10000000;
	localparam int unsigned PWM_HZ = 18;
	localparam int unsigned PWM_STEPS = 100;
	localparam int unsigned CYC_PWM_STEP = CLK_HZ / (PWM_HZ * PWM_STEPS);
	localparam int unsigned TICK_HZ = 32;
	localparam int unsigned CYC_TICK = CLK_HZ / TICK_HZ;
	localparam int unsigned TICKS_SEC = 32;
	localparam int unsigned HOLD_LONG_SEC = 4;
	localparam int unsigned HOLD_SHORT_TICKS = 8;
	localparam int unsigned EXTRA_SEC = 5;
	localparam int unsigned RESET_PULSE_SEC = 1;
	localparam logic [7:0] DEF_PULSE_TICKS = 8'h20;
	localparam logic [7:0] DEF_BLANK = 8'h01;
	// ------------------------------------------------------------
	// Wishbone register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_ARG0 = 8'h04;
	localparam logic [7:0] A_ARG1 = 8'h08;
	localparam logic [7:0] A_REPLY = 8'h0c;
	localparam logic [7:0] A_DATA0 = 8'h10;
	localparam logic [7:0] A_DATA1 = 8'h14;
	localparam logic [7:0] A_STATUS = 8'h18;
	localparam logic [7:0] A_FANPWR = 8'h1c;
	// ------------------------------------------------------------
	// Request and reply types, enable mask bits
	// ------------------------------------------------------------
	localparam logic [7:0] T_BLANK = 8'h1a;
	localparam logic [7:0] T_QUERY = 8'h1b;
	localparam logic [7:0] T_ENABLE = 8'h1c;
	localparam logic [7:0] T_WDOG = 8'h1d;
	localparam logic [7:0] T_REPLY_BIT = 8'h40;
	localparam int unsigned B_AUTO = 0;
	localparam int unsigned B_RSTINV = 1;
	localparam int unsigned B_PWRINV = 2;
	localparam int unsigned B_BLANK = 4;
	localparam int unsigned B_KRST = 5;
	localparam int unsigned B_KON = 6;
	localparam int unsigned B_KOFF = 7;
	// Command word layout: [7:0] type, [10:8] payload length
	localparam int unsigned CMD_LEN_LO = 8;
	// Keypad action sequencer states
	typedef enum logic [5:0] {
		HPS_IDLE = 6'h01,
		HPS_HOLD = 6'h02,
		HPS_PULSE = 6'h04,
		HPS_EXTRA = 6'h08,
		HPS_LOCK = 6'h10,
		HPS_WAITREL = 6'h20
	} hps_state_t;
endpackage

// ### logic/hps_fan_if.sv
// Interface: one fan's PWM phase and blanking link
`timescale 1ns/1ns
interface hps_fan_if;
	logic [6:0] phase;
	logic stepTick;
	logic [7:0] power;
	logic [7:0] delay;
	logic pwmOn;
	logic tachOk;
	modport ctrl (output phase, output stepTick, output power,
		output delay, input pwmOn, input tachOk);
	modport fan (input phase, input stepTick, input power,
		input delay, output pwmOn, output tachOk);
endinterface

// ### logic/hps_fan_chan.sv
// Module: one fan channel, PWM output and tachometer blanking window
`timescale 1ns/1ns
module hps_fan_chan
	import hps_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	hps_fan_if.fan f
);
	logic [7:0] blankCnt_q;
	logic onNow;
	logic wasOn_q;
	// ------------------------------------------------------------
	// PWM compare: on while phase below power percentage
	// ------------------------------------------------------------
	assign onNow = {1'b0, f.phase} < f.power;
	assign f.pwmOn = wasOn_q;
	assign f.tachOk = wasOn_q && (blankCnt_q == 8'h00);
	// Blanking restarts at every off-to-on edge of the PWM
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wasOn_q <= 1'b0;
			blankCnt_q <= 8'h00;
		end else if (ce && f.stepTick) begin
			wasOn_q <= onNow;
			if (onNow && !wasOn_q) begin
				blankCnt_q <= f.delay;
			end else if (blankCnt_q != 8'h00) begin
				blankCnt_q <= blankCnt_q - 8'h01;
			end
		end
	end
endmodule

// ### verif/hps_monitor.sv
// Checker: bus handshake, control pulses and display relations
`timescale 1ns/1ns
module hps_monitor #(
	parameter int unsigned NFAN = 4,
	parameter int unsigned CYC_TK = 10
)(
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic hostAlive,
	input wire logic [NFAN-1:0] tachIn,
	input wire logic [NFAN-1:0] fanPwm,
	input wire logic [NFAN-1:0] tachValid,
	input wire logic hostResetOut,
	input wire logic hostResetOe,
	input wire logic hostPowerOe,
	input wire logic displayBlank,
	input wire logic selfRestart,
	input wire logic [1:0] msgSel
);
	// ----------------------------------------
	// Pulse length counters
	// ----------------------------------------
	logic [31:0] rstCnt_q;
	logic [31:0] pwrCnt_q;
	// Cycles a line has been driven; cleared once released
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rstCnt_q <= '0;
			pwrCnt_q <= '0;
		end else begin
			rstCnt_q <= hostResetOe ? rstCnt_q + 32'h1 : 32'h0;
			pwrCnt_q <= hostPowerOe ? pwrCnt_q + 32'h1 : 32'h0;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	chk_ack_next: assert property (
		wb_cyc_i && wb_stb_i && ce && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_tach_gated: assert property (
		(tachValid & ~tachIn) == '0)
		else $error("tach valid without tach input");
	chk_tach_blank: assert property (
		$rose(fanPwm[0]) |-> !tachValid[0])
		else $error("tach not blanked at turn-on");
	chk_rst_len: assert property (
		$fell(hostResetOe) |->
		rstCnt_q >= 31 * CYC_TK && rstCnt_q <= 32 * CYC_TK + 1)
		else $error("reset pulse length wrong");
	chk_pwr_len: assert property (
		hostPowerOe |-> pwrCnt_q <= 417 * CYC_TK)
		else $error("power line driven too long");
	chk_rst_level: assert property (
		hostResetOe && $past(hostResetOe) |-> $stable(hostResetOut))
		else $error("reset level changed in pulse");
	chk_blank_down: assert property (
		displayBlank |-> !hostAlive)
		else $error("display blank while host alive");
	chk_restart_held: assert property (
		selfRestart |=> selfRestart)
		else $error("restart request dropped");
	chk_pwr_msg: assert property (
		$rose(hostPowerOe) |-> ##[0:1] msgSel inside {2'h2, 2'h3})
		else $error("no power message");
	// Main scenarios reached
	cover property ($rose(hostResetOe));
	cover property ($rose(hostPowerOe));
	cover property (displayBlank);
endmodule

bind hps_supervisor hps_monitor #(.NFAN(NFAN), .CYC_TK(CYC_TK)) i_hps_monitor (
	.mclk(mclk), .reset(reset), .ce(ce), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .hostAlive(hostAlive),
	.tachIn(tachIn), .fanPwm(fanPwm), .tachValid(tachValid),
	.hostResetOut(hostResetOut), .hostResetOe(hostResetOe),
	.hostPowerOe(hostPowerOe), .displayBlank(displayBlank),
	.selfRestart(selfRestart), .msgSel(msgSel)
);

// ### verif/hps_host_model.sv
// Host model: Wishbone master sending request packets
`timescale 1ns/1ns
module hps_host_model
	import hps_pkg::*;
(
	input wire logic mclk,
	input wire logic ack,
	input wire logic [31:0] datI,
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] datO
);
	// Bus idle at start; address, select and data outputs held at zero
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		datO = 32'h0;
	end
	// One classic cycle, held until ack is sampled high
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		datO <= d;
		do @(posedge mclk); while (ack !== 1'b1);
		q = datI;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	// Payload bytes first, then the type word, then the reply
	task automatic send(input logic [7:0] t, input logic [2:0] n,
		input logic [31:0] arg, output logic [31:0] rep);
		logic [31:0] q;
		if (n != 3'h0) xfer(1'b1, A_ARG0, arg, q);
		xfer(1'b1, A_CMD, {21'h0, n, t}, q);
		xfer(1'b0, A_REPLY, 32'h0, rep);
	endtask
endmodule

// ### verif/hps_supervisor_tb.sv
// Testbench: keys, host link and fan inputs of the supervisor
`timescale 1ns/1ns
module hps_supervisor_tb;
	import hps_pkg::*;
	localparam int TK = 10;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic cyc, stb, we, ack;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] datW, datR, rep;
	logic hostAlive = 1'b1;
	logic keyConfirm = 1'b0;
	logic keyCancel = 1'b0;
	logic [3:0] tachIn = 4'hf;
	logic [3:0] failSafeMask = 4'h5;
	logic [3:0] fanPwm, tachValid;
	logic rOut, rOe, pOut, pOe, displayBlank, selfRestart;
	logic [1:0] msgSel;
	int numErrors = 0;
	int nTests = 0;
	int n;
	logic [2:0] st;
	always #50 mclk = ~mclk;
	hps_supervisor #(.NFAN(4), .CYC_STEP(4), .CYC_TK(TK)) i_hps_supervisor (
		.mclk(mclk), .reset(reset), .ce(ce), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
		.hostAlive(hostAlive), .keyConfirm(keyConfirm),
		.keyCancel(keyCancel), .tachIn(tachIn),
		.failSafeMask(failSafeMask), .fanPwm(fanPwm),
		.tachValid(tachValid), .hostResetOut(rOut), .hostResetOe(rOe),
		.hostPowerOut(pOut), .hostPowerOe(pOe),
		.displayBlank(displayBlank), .selfRestart(selfRestart),
		.msgSel(msgSel));
	hps_host_model i_hps_host_model (.mclk(mclk), .ack(ack), .datI(datR),
		.cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .datO(datW));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic conclude();
		$display("errors %0d tests %0d", numErrors, nTests);
		if (numErrors == 0 && nTests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			numErrors++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic ok);
		nTests++;
		if (ok !== 1'b1) begin
			numErrors++;
			$display("mismatch %0t check false", $time);
		end
	endtask
	task automatic rst();
		reset <= 1'b1;
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic send(input logic [7:0] t, input logic [2:0] len,
		input logic [31:0] arg, input logic [31:0] exp);
		logic [31:0] r;
		i_hps_host_model.send(t, len, arg, r);
		cmp(r, exp);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		i_hps_host_model.xfer(1'b0, a, 32'h0, r);
		cmp(r, exp);
	endtask
	// Length of the next pulse; level and message taken on its third cycle
	task automatic pulse(input bit p, input int lim);
		n = 0;
		st = 3'h0;
		for (int i = 0; i < lim && (p ? pOe : rOe) !== 1'b1; i++)
			@(negedge mclk);
		while ((p ? pOe : rOe) === 1'b1) begin
			@(negedge mclk);
			n++;
			if (n == 2) st = {msgSel, p ? pOut : rOut};
		end
		@(posedge mclk);
	endtask
	// Cycles from fan turn-on until its tach is seen
	task automatic tach(input int i, input int lo, input int hi);
		int c;
		c = 0;
		@(negedge mclk);
		while (fanPwm[i] !== 1'b0) @(negedge mclk);
		while (fanPwm[i] !== 1'b1) @(negedge mclk);
		while (tachValid[i] !== 1'b1 && c < 400) begin
			c++;
			@(negedge mclk);
		end
		chkb(c >= lo && c <= hi);
		@(posedge mclk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_fans();
		i_hps_host_model.xfer(1'b1, A_FANPWR, 32'h32323232, rep);
		tach(0, 3, 5);
		send(T_BLANK, 3'h4, 32'h04030201, 32'h5a);
		tach(2, 11, 13);
		tach(3, 15, 17);
		tachIn <= 4'h0;
		repeat (2) @(posedge mclk);
		cmp(tachValid, 4'h0);
		tachIn <= 4'hf;
		send(T_QUERY, 3'h0, 32'h0, 32'h5b);
		rd(A_DATA0, 32'h32323232);
		rd(A_DATA1, 32'h5);
		rd(8'h40, 32'h0);
	endtask
	task automatic t_kreset();
		send(T_ENABLE, 3'h1, 32'h22, 32'h5c);
		keyConfirm <= 1'b1;
		repeat (100 * TK) @(posedge mclk);
		keyConfirm <= 1'b0;
		pulse(0, 400);
		cmp(n, 0);
		keyConfirm <= 1'b1;
		pulse(0, 140 * TK);
		keyConfirm <= 1'b0;
		chkb(n >= 31 * TK && n <= 32 * TK + 1);
		cmp(st, 3'b011);
		chkb(selfRestart === 1'b1);
		send(T_WDOG, 3'h1, 32'h1, 32'h5c);
		rst();
	endtask
	task automatic t_power();
		hostAlive <= 1'b0;
		send(T_ENABLE, 3'h2, 32'h0440, 32'h5c);
		keyConfirm <= 1'b1;
		pulse(1, 12 * TK);
		keyConfirm <= 1'b0;
		chkb(n >= 3 * TK && n <= 4 * TK + 1);
		cmp(st, 3'b100);
		chkb(selfRestart === 1'b1);
		rst();
		hostAlive <= 1'b1;
		send(T_ENABLE, 3'h1, 32'h84, 32'h5c);
		keyCancel <= 1'b1;
		pulse(1, 140 * TK);
		keyCancel <= 1'b0;
		chkb(n >= 191 * TK && n <= 192 * TK + 1);
		cmp(st, 3'b111);
		rst();
	endtask
	task automatic t_blank();
		hostAlive <= 1'b0;
		repeat (4) @(posedge mclk);
		chkb(displayBlank === 1'b0);
		send(T_ENABLE, 3'h1, 32'h10, 32'h5c);
		repeat (4) @(posedge mclk);
		chkb(displayBlank === 1'b1);
		hostAlive <= 1'b1;
		repeat (8) @(posedge mclk);
		chkb(selfRestart === 1'b1);
		rst();
	endtask
	task automatic t_wdog();
		send(T_WDOG, 3'h1, 32'h1, 32'h5d);
		rd(A_STATUS, 32'h00010010);
		repeat (200) @(posedge mclk);
		send(T_WDOG, 3'h1, 32'h0, 32'h5d);
		pulse(0, 600);
		cmp(n, 0);
		send(T_WDOG, 3'h1, 32'h1, 32'h5d);
		repeat (200) @(posedge mclk);
		send(T_WDOG, 3'h1, 32'h1, 32'h5d);
		pulse(0, 250);
		cmp(n, 0);
		pulse(0, 200);
		chkb(n >= 31 * TK && n <= 32 * TK + 1);
		cmp(st[0], 1'b0);
		pulse(0, 800);
		cmp(n, 0);
		rd(A_STATUS, 32'h00000010);
	endtask
	// Main sequence
	initial begin
		rst();
		t_fans();
		t_kreset();
		t_power();
		t_blank();
		t_wdog();
		conclude();
	end
	// Hang guard, well beyond the expected run of about 10000 cycles
	initial begin
		repeat (40000) @(posedge mclk);
		numErrors++;
		conclude();
	end
endmodule
